// file: ipd_regs.vh
// Constants for the instruction parcel decoder: field layout, counts and states
`ifndef IPD_REGS_VH
`define IPD_REGS_VH

// Parcel and word geometry
`define IPD_PARCEL_W 16
`define IPD_WORD_W 64
`define IPD_PARCELS_PER_WORD 4
`define IPD_PIDX_W 2

// Parcel field positions
`define IPD_OPC_HI 15
`define IPD_OPC_LO 9
`define IPD_OPC_W 7
`define IPD_DI_HI 8
`define IPD_DI_LO 6
`define IPD_DJ_HI 5
`define IPD_DJ_LO 3
`define IPD_DK_HI 2
`define IPD_DK_LO 0
`define IPD_DES_W 3

// Trailing constant parcel counts
`define IPD_CLEN_W 3
`define IPD_CLEN_NONE 3'h0
`define IPD_CLEN_ONE 3'h1
`define IPD_CLEN_TWO 3'h2
`define IPD_CLEN_FOUR 3'h4

// Designator used mask bits
`define IPD_USE_I 2
`define IPD_USE_J 1
`define IPD_USE_K 0

// Program address after reset
`define IPD_RESET_PA 24'h000000
`define IPD_PA_W 24

// Sequencer states
`define IPD_ST_INSTR 2'h0
`define IPD_ST_CONST 2'h1
`define IPD_ST_ISSUE 2'h2

`endif

// file: ipd_parcel_sel.v
// Parcel selector: picks one 16-bit parcel out of a packed memory word
`timescale 1ns/100ps
`default_nettype none
`include "ipd_regs.vh"

module ipd_parcel_sel #(
  parameter PARCEL_W = `IPD_PARCEL_W,
  parameter NPARCEL = `IPD_PARCELS_PER_WORD,
  parameter IDX_W = `IPD_PIDX_W
) (
  input wire [PARCEL_W*NPARCEL-1:0] word_i,
  input wire [IDX_W-1:0] idx_i,
  output wire [PARCEL_W-1:0] parcel_o
);

  wire [PARCEL_W-1:0] lane [0:NPARCEL-1];

  // Parcel 0 is the high-order lane of the word
  genvar g;
  generate
    for (g = 0; g < NPARCEL; g = g + 1) begin : g_lane
      assign lane[g] = word_i[PARCEL_W*(NPARCEL-g)-1 -: PARCEL_W];
    end
  endgenerate

  assign parcel_o = lane[idx_i];

endmodule // ipd_parcel_sel
`default_nettype wire

// file: ipd_fmt_dec.v
// Format decoder: constant parcel count and designator usage per opcode
`timescale 1ns/100ps
`default_nettype none
`include "ipd_regs.vh"

module ipd_fmt_dec #(
  parameter [6:0] ONE_LO = 7'h30,
  parameter [6:0] ONE_HI = 7'h33,
  parameter [6:0] TWO_LO = 7'h34,
  parameter [6:0] TWO_HI = 7'h35,
  parameter [6:0] FOUR_LO = 7'h36,
  parameter [6:0] FOUR_HI = 7'h36
) (
  input wire [`IPD_OPC_W-1:0] opcode_i,
  output wire [`IPD_CLEN_W-1:0] const_len_o,
  output wire [2:0] used_o
);

  // Number of trailing constant parcels
  function [`IPD_CLEN_W-1:0] clen;
    input [6:0] op;
    begin
      if ((op >= 7'h03 && op <= 7'h05) || (op >= 7'h08 && op <= 7'h0f))
        clen = `IPD_CLEN_TWO;
      else if (op >= ONE_LO && op <= ONE_HI)
        clen = `IPD_CLEN_ONE;
      else if (op >= TWO_LO && op <= TWO_HI)
        clen = `IPD_CLEN_TWO;
      else if (op >= FOUR_LO && op <= FOUR_HI)
        clen = `IPD_CLEN_FOUR;
      else
        clen = `IPD_CLEN_NONE;
    end
  endfunction

  // Which of i, j, k the opcode actually reads
  function [2:0] uses;
    input [6:0] op;
    begin
      if (op == 7'h00)
        uses = 3'h3;
      else if (op >= 7'h01 && op <= 7'h07)
        uses = (op == 7'h02) ? 3'h5 : 3'h0;
      else if (op >= 7'h08 && op <= 7'h0b)
        uses = 3'h1;
      else if (op >= 7'h0c && op <= 7'h0f)
        uses = 3'h2;
      else
        uses = 3'h7;
    end
  endfunction

  assign const_len_o = clen(opcode_i); // [RULE8]
  assign used_o = uses(opcode_i); // [RULE15]

endmodule // ipd_fmt_dec
`default_nettype wire

// file: ipd_decoder.v
// Instruction parcel fetch, format decode and constant assembly
`timescale 1ns/100ps
`default_nettype none
`include "ipd_regs.vh"

// Functional notes
// RULE1: Every instruction is handled as 16-bit parcels, each taken as instruction or constant.
// RULE2: A fetched memory word is split into four parcels, all from that one word.
// RULE3: Program addresses count parcels, four per word, each 16 bits.
// RULE4: The operation comes from the opcode field of the instruction parcel.
// RULE5: Three designator fields select registers in a three-address form.
// RULE6: The first designator normally names the destination register.
// RULE7: The second and third designators normally name the source registers.
// RULE8: Per opcode, zero, one, two or four constant parcels follow the instruction.
// RULE9: A single constant parcel is normally a local memory address.
// RULE10: Two constant parcels form a main memory address or a 32-bit register value.
// RULE11: Four constant parcels form a 64-bit value for a scalar register.
// RULE12: The program address advances past all consumed constant parcels.
// RULE13: The first constant parcel read is the most significant part of the constant.
// RULE14: The opcode is the top seven bits, followed by three octal-digit designators.
// RULE15: Designator fields an opcode does not use are ignored.
// RULE16: Opcode sits in bits 15..9, designators in 8..6, 5..3 and 2..0.
// RULE17: Issue waits until all constant parcels are in, even across a word boundary.
module ipd_decoder #(
  parameter PA_W = `IPD_PA_W,
  parameter [PA_W-1:0] RESET_PA = `IPD_RESET_PA
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  // Memory word fetch
  output reg fetch_req_o,
  output reg [PA_W-3:0] fetch_addr_o,
  input wire mem_valid_i,
  input wire [`IPD_WORD_W-1:0] mem_word_i,
  // Branch redirect
  input wire jump_i,
  input wire [PA_W-1:0] jump_addr_i,
  // Decoded instruction
  output reg issue_o,
  input wire issue_ready_i,
  output reg [PA_W-1:0] issue_pa_o,
  output reg [PA_W-1:0] next_pa_o,
  output reg [`IPD_OPC_W-1:0] opcode_o,
  output reg [`IPD_DES_W-1:0] dest_sel_o,
  output reg [`IPD_DES_W-1:0] src_j_sel_o,
  output reg [`IPD_DES_W-1:0] src_k_sel_o,
  output reg [2:0] field_used_o,
  output reg [`IPD_CLEN_W-1:0] const_len_o,
  output reg [`IPD_WORD_W-1:0] const_o,
  output reg [PA_W-1:0] lmem_addr_o,
  output reg [PA_W-1:0] cmem_addr_o
);

  // Sequencer state, read pointer, word buffer and accumulator
  reg [1:0] state;
  reg [PA_W-1:0] rd_pa;
  reg [`IPD_WORD_W-1:0] buf_word;
  reg [PA_W-3:0] buf_waddr;
  reg buf_ok;
  reg [`IPD_CLEN_W-1:0] remain;
  reg [`IPD_WORD_W-1:0] acc;

  // Next values for every sequencer and output register
  reg [1:0] next_state;
  reg [PA_W-1:0] next_rd_pa;
  reg [`IPD_CLEN_W-1:0] next_remain;
  reg [`IPD_WORD_W-1:0] next_acc;
  reg next_fetch_req;
  reg [PA_W-3:0] next_fetch_addr;
  reg next_issue;
  reg [PA_W-1:0] next_issue_pa;
  reg [PA_W-1:0] next_next_pa;
  reg [`IPD_OPC_W-1:0] next_opcode;
  reg [`IPD_DES_W-1:0] next_dest;
  reg [`IPD_DES_W-1:0] next_src_j;
  reg [`IPD_DES_W-1:0] next_src_k;
  reg [2:0] next_used;
  reg [`IPD_CLEN_W-1:0] next_clen;
  reg [`IPD_WORD_W-1:0] next_const;
  reg [PA_W-1:0] next_lmem;
  reg [PA_W-1:0] next_cmem;

  wire [`IPD_PARCEL_W-1:0] parcel;
  wire [`IPD_CLEN_W-1:0] dec_clen;
  wire [2:0] dec_used;
  wire [`IPD_WORD_W-1:0] acc_shift;
  wire need;
  wire hit;
  wire take_word;

  // Sequencer states; binary coded, the spare code falls back to fetch
  localparam [1:0] ST_INSTR = `IPD_ST_INSTR;
  localparam [1:0] ST_CONST = `IPD_ST_CONST;
  localparam [1:0] ST_ISSUE = `IPD_ST_ISSUE;

  // Word address holding a parcel: drop the two lane bits
  function [PA_W-3:0] word_of;
    input [PA_W-1:0] pa;
    begin
      word_of = pa[PA_W-1:2]; // [RULE3]
    end
  endfunction

  // Designator field, or zero when the opcode ignores it
  function [`IPD_DES_W-1:0] pick;
    input use_bit;
    input [`IPD_DES_W-1:0] field;
    begin
      if (use_bit)
        pick = field;
      else
        pick = {`IPD_DES_W{1'b0}}; // [RULE15]
    end
  endfunction

  // The buffered word marks the parcel at the read pointer as present
  assign hit = buf_ok && (buf_waddr == word_of(rd_pa)); // [RULE3]
  assign need = (state == ST_INSTR) || (state == ST_CONST);
  // Only a request that is still up takes the memory answer
  assign take_word = fetch_req_o && mem_valid_i;
  // High-order parcel first: older parcels move up as new ones land low
  assign acc_shift = {acc[`IPD_WORD_W-`IPD_PARCEL_W-1:0], parcel}; // [RULE13]

  // Lane select within the buffered word
  ipd_parcel_sel u_sel (
    .word_i(buf_word),
    .idx_i(rd_pa[1:0]),
    .parcel_o(parcel)
  ); // [RULE2]

  // Constant count and designator usage from the opcode field
  ipd_fmt_dec u_fmt (
    .opcode_i(parcel[`IPD_OPC_HI:`IPD_OPC_LO]),
    .const_len_o(dec_clen),
    .used_o(dec_used)
  );

  // Word buffer; one word covers four consecutive parcel addresses
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_word <= 64'h0000000000000000;
      buf_waddr <= {(PA_W-2){1'b0}};
      buf_ok <= 1'b0;
    end else if (ce_i) begin
      // A stale answer after a redirect still loads; the tag compare rejects it
      if (take_word) begin
        buf_word <= mem_word_i; // [RULE2]
        buf_waddr <= fetch_addr_o;
        buf_ok <= 1'b1;
      end
    end
  end

  // Sequencer next values
  always @* begin
    next_state = state;
    next_rd_pa = rd_pa;
    next_remain = remain;
    next_acc = acc;
    next_issue = issue_o;
    next_issue_pa = issue_pa_o;
    next_next_pa = next_pa_o;
    next_opcode = opcode_o;
    next_dest = dest_sel_o;
    next_src_j = src_j_sel_o;
    next_src_k = src_k_sel_o;
    next_used = field_used_o;
    next_clen = const_len_o;
    next_const = const_o;
    next_lmem = lmem_addr_o;
    next_cmem = cmem_addr_o;
    // Fetch stays up until the word arrives; a miss raises it
    next_fetch_addr = fetch_addr_o;
    if (fetch_req_o) begin
      next_fetch_req = !mem_valid_i;
    end else begin
      next_fetch_req = need && !hit && !jump_i; // [RULE17]
      if (need && !hit) begin
        next_fetch_addr = word_of(rd_pa); // [RULE3]
      end
    end
    if (jump_i) begin
      // Redirect wins over any decode in progress
      next_state = ST_INSTR;
      next_rd_pa = jump_addr_i;
      next_issue = 1'b0;
      next_remain = `IPD_CLEN_NONE;
    end else begin
      case (state)
        ST_INSTR: begin
          if (hit) begin
            // Whole parcel taken as an instruction
            next_opcode = parcel[`IPD_OPC_HI:`IPD_OPC_LO]; // [RULE4] [RULE14] [RULE16]
            next_dest = pick(dec_used[`IPD_USE_I],
                             parcel[`IPD_DI_HI:`IPD_DI_LO]); // [RULE6] [RULE15]
            next_src_j = pick(dec_used[`IPD_USE_J],
                              parcel[`IPD_DJ_HI:`IPD_DJ_LO]); // [RULE7] [RULE5]
            next_src_k = pick(dec_used[`IPD_USE_K],
                              parcel[`IPD_DK_HI:`IPD_DK_LO]); // [RULE7] [RULE15]
            next_used = dec_used;
            next_clen = dec_clen;
            next_issue_pa = rd_pa;
            next_rd_pa = rd_pa + 1'b1; // [RULE3]
            next_remain = dec_clen;
            next_acc = 64'h0000000000000000;
            if (dec_clen == `IPD_CLEN_NONE) begin
              next_const = 64'h0000000000000000;
              next_lmem = {PA_W{1'b0}};
              next_cmem = {PA_W{1'b0}};
              next_next_pa = rd_pa + 1'b1;
              next_issue = 1'b1;
              next_state = ST_ISSUE;
            end else begin
              next_state = ST_CONST; // [RULE8]
            end
          end
        end
        ST_CONST: begin
          if (hit) begin
            // Parcel taken as constant data, may sit in the next word
            next_acc = acc_shift; // [RULE1] [RULE13]
            next_rd_pa = rd_pa + 1'b1; // [RULE12]
            next_remain = remain - 1'b1;
            if (remain == `IPD_CLEN_ONE) begin
              // Last parcel in: publish the constant and the address past it
              next_const = acc_shift; // [RULE11]
              next_lmem = {PA_W{1'b0}};
              next_cmem = {PA_W{1'b0}};
              if (const_len_o == `IPD_CLEN_ONE) begin
                next_lmem = acc_shift[PA_W-1:0]; // [RULE9]
              end
              if (const_len_o == `IPD_CLEN_TWO) begin
                next_cmem = acc_shift[PA_W-1:0]; // [RULE10]
              end
              next_next_pa = rd_pa + 1'b1; // [RULE12]
              next_issue = 1'b1; // [RULE17]
              next_state = ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          // Hold the decoded instruction until the consumer takes it
          if (issue_ready_i) begin
            next_issue = 1'b0;
            next_state = ST_INSTR;
          end
        end
        default: begin
          // Spare code: drop any issue and resume fetching
          next_state = ST_INSTR;
          next_issue = 1'b0;
        end
      endcase
    end
  end

  // Sequencer and decoded output registers
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_INSTR;
      rd_pa <= RESET_PA;
      remain <= `IPD_CLEN_NONE;
      acc <= 64'h0000000000000000;
      fetch_req_o <= 1'b0;
      fetch_addr_o <= {(PA_W-2){1'b0}};
      issue_o <= 1'b0;
      issue_pa_o <= {PA_W{1'b0}};
      next_pa_o <= RESET_PA;
      opcode_o <= 7'h00;
      dest_sel_o <= 3'h0;
      src_j_sel_o <= 3'h0;
      src_k_sel_o <= 3'h0;
      field_used_o <= 3'h0;
      const_len_o <= `IPD_CLEN_NONE;
      const_o <= 64'h0000000000000000;
      lmem_addr_o <= {PA_W{1'b0}};
      cmem_addr_o <= {PA_W{1'b0}};
    end else if (ce_i) begin
      state <= next_state;
      rd_pa <= next_rd_pa;
      remain <= next_remain;
      acc <= next_acc;
      fetch_req_o <= next_fetch_req;
      fetch_addr_o <= next_fetch_addr;
      issue_o <= next_issue;
      issue_pa_o <= next_issue_pa;
      next_pa_o <= next_next_pa;
      opcode_o <= next_opcode;
      dest_sel_o <= next_dest;
      src_j_sel_o <= next_src_j;
      src_k_sel_o <= next_src_k;
      field_used_o <= next_used;
      const_len_o <= next_clen;
      const_o <= next_const;
      lmem_addr_o <= next_lmem;
      cmem_addr_o <= next_cmem;
    end
  end

endmodule // ipd_decoder
`default_nettype wire

// file: ipd_decoder_end_marker_unused.v
// Empty source unit: no module lives here
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: ipd_decoder_sva.sv
// Port assertions for the parcel decoder
`timescale 1ns/100ps
`default_nettype none
module ipd_decoder_sva #(parameter PA_W = 24) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic fetch_req_o,
  input wire logic [PA_W-3:0] fetch_addr_o,
  input wire logic mem_valid_i,
  input wire logic jump_i,
  input wire logic issue_o,
  input wire logic issue_ready_i,
  input wire logic [PA_W-1:0] issue_pa_o,
  input wire logic [PA_W-1:0] next_pa_o,
  input wire logic [6:0] opcode_o,
  input wire logic [2:0] dest_sel_o,
  input wire logic [2:0] field_used_o,
  input wire logic [2:0] const_len_o,
  input wire logic [63:0] const_o,
  input wire logic [PA_W-1:0] lmem_addr_o,
  input wire logic [PA_W-1:0] cmem_addr_o
);
  // Constant count the shown opcode calls for
  wire logic [2:0] exp_len;
  assign exp_len = (opcode_o inside {[7'h03:7'h05], [7'h08:7'h0f], 7'h34, 7'h35}) ? 3'h2 :
    (opcode_o inside {[7'h30:7'h33]}) ? 3'h1 : (opcode_o == 7'h36) ? 3'h4 : 3'h0;
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  req_hold_a: assert property (
    fetch_req_o && !mem_valid_i |=> fetch_req_o && $stable(fetch_addr_o))
    else $error("fetch request moved before answer");
  req_drop_a: assert property (fetch_req_o && mem_valid_i && ce_i |=> !fetch_req_o)
    else $error("fetch request kept after answer");
  issue_hold_a: assert property (
    issue_o && !issue_ready_i && !jump_i |=> issue_o && $stable(const_o))
    else $error("issue dropped or changed while waiting");
  accept_done_a: assert property (issue_o && issue_ready_i && ce_i |=> !issue_o)
    else $error("issue held after acceptance");
  jump_drop_a: assert property (jump_i && ce_i |=> !issue_o)
    else $error("issue kept after redirect");
  next_pa_a: assert property (issue_o |-> next_pa_o == issue_pa_o + 1 + const_len_o)
    else $error("next address not past constants");
  const_len_a: assert property (issue_o |-> const_len_o == exp_len)
    else $error("constant count wrong for opcode");
  const_align_a: assert property (issue_o |-> (const_o >> (const_len_o * 16)) == 64'h0)
    else $error("constant not right aligned");
  lmem_addr_a: assert property (
    issue_o && const_len_o == 3'h1 |-> lmem_addr_o == const_o[23:0])
    else $error("local address mismatch");
  cmem_addr_a: assert property (
    issue_o && const_len_o == 3'h2 |-> cmem_addr_o == const_o[23:0])
    else $error("main address mismatch");
  dest_unused_a: assert property (issue_o |-> field_used_o[2] || dest_sel_o == 3'h0)
    else $error("unused destination not cleared");
endmodule // ipd_decoder_sva
bind ipd_decoder ipd_decoder_sva #(.PA_W(PA_W)) u_ipd_decoder_sva (.clk_sys_i, .rst_n_i, .ce_i,
  .fetch_req_o, .fetch_addr_o, .mem_valid_i, .jump_i, .issue_o, .issue_ready_i, .issue_pa_o,
  .next_pa_o, .opcode_o, .dest_sel_o, .field_used_o, .const_len_o, .const_o, .lmem_addr_o,
  .cmem_addr_o);
`default_nettype wire

// file: ipd_mem_model.sv
// Main memory model answering word fetches
`timescale 1ns/100ps
`default_nettype none
module ipd_mem_model (
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [21:0] addr_i,
  output var logic valid_o,
  output var logic [63:0] word_o
);
  logic [63:0] mem [0:63];
  initial begin
    valid_o = 1'b0;
    word_o = 64'h0;
  end
  // One-cycle answer, prompt or after random stalls; idle data toggles so it is never reused
  always @(negedge clk_sys_i) begin
    if (!valid_o && req_i && (!slow_i || $urandom_range(3) == 0)) begin
      valid_o <= 1'b1;
      word_o <= mem[addr_i[5:0]];
    end else begin
      valid_o <= 1'b0;
      word_o <= ~word_o;
    end
  end
endmodule // ipd_mem_model
`default_nettype wire

// file: test_instruction_parcel_decoder.sv
// Self-checking bench for the parcel decoder
`timescale 1ns/100ps
`default_nettype none
module test_instruction_parcel_decoder;
  logic clk_sys_i, rst_n_i, ce_i, jump_i, issue_ready_i, slow, fetch_req_o, mem_valid_i, issue_o;
  logic [21:0] fetch_addr_o;
  logic [63:0] mem_word_i, const_o;
  logic [23:0] jump_addr_i, issue_pa_o, next_pa_o, lmem_addr_o, cmem_addr_o, pa, tpa [0:23];
  logic [6:0] opcode_o;
  logic [2:0] dest_sel_o, src_j_sel_o, src_k_sel_o, field_used_o, const_len_o;
  logic [15:0] prog [0:255];
  int n_mismatch = 0, cmp_count = 0, i, k;

  ipd_decoder u_ipd_decoder (.clk_sys_i, .rst_n_i, .ce_i, .fetch_req_o, .fetch_addr_o,
    .mem_valid_i, .mem_word_i, .jump_i, .jump_addr_i, .issue_o, .issue_ready_i, .issue_pa_o,
    .next_pa_o, .opcode_o, .dest_sel_o, .src_j_sel_o, .src_k_sel_o, .field_used_o,
    .const_len_o, .const_o, .lmem_addr_o, .cmem_addr_o);
  ipd_mem_model u_ipd_mem_model (.clk_sys_i, .slow_i(slow), .req_i(fetch_req_o),
    .addr_i(fetch_addr_o), .valid_o(mem_valid_i), .word_o(mem_word_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [2:0] clen(input logic [6:0] op);
    if (op inside {[7'h03:7'h05], [7'h08:7'h0f], 7'h34, 7'h35}) return 3'h2;
    if (op inside {[7'h30:7'h33]}) return 3'h1;
    return (op == 7'h36) ? 3'h4 : 3'h0;
  endfunction
  function automatic logic [2:0] used(input logic [6:0] op);
    if (op == 7'h00) return 3'h3;
    if (op == 7'h02) return 3'h5;
    if (op inside {7'h01, [7'h03:7'h07]}) return 3'h0;
    if (op inside {[7'h08:7'h0b]}) return 3'h1;
    return (op inside {[7'h0c:7'h0f]}) ? 3'h2 : 3'h7;
  endfunction
  // First constant parcel lands highest
  function automatic logic [63:0] cval(input logic [23:0] a, input logic [2:0] n);
    cval = 64'h0;
    for (int m = 1; m <= n; m++) cval = {cval[47:0], prog[(a + m) % 256]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_issue();
    logic [15:0] p;
    logic [2:0] u, n;
    logic [63:0] c;
    p = prog[pa % 256];
    u = used(p[15:9]);
    n = clen(p[15:9]);
    c = cval(pa, n);
    chk(issue_pa_o, pa, "pa");
    chk(opcode_o, p[15:9], "opcode");
    chk(dest_sel_o, u[2] ? p[8:6] : 3'h0, "dest");
    chk(src_j_sel_o, u[1] ? p[5:3] : 3'h0, "src j");
    chk(src_k_sel_o, u[0] ? p[2:0] : 3'h0, "src k");
    chk({field_used_o, const_len_o}, {u, n}, "format");
    chk(const_o, c, "const");
    chk(lmem_addr_o, n == 3'h1 ? c : 64'h0, "lmem");
    chk(cmem_addr_o, n == 3'h2 ? c[23:0] : 24'h0, "cmem");
    chk(next_pa_o, pa + 1 + n, "next");
    pa = pa + 1 + n;
  endtask

  // Accept cnt instructions under random back pressure
  task automatic run(input int cnt);
    int w;
    w = 0;
    while (cnt > 0 && w < 200) begin
      @(negedge clk_sys_i);
      issue_ready_i = ($urandom_range(3) != 0);
      ce_i = ($urandom_range(7) != 0);
      w++;
      if (issue_o === 1'b1 && issue_ready_i && ce_i) begin
        check_issue();
        cnt--;
        w = 0;
      end
    end
    if (w >= 200) chk(1'b1, 1'b0, "issue stalled");
    $display("test done at %0t", $time);
  endtask

  // Redirect with acceptance held off, since redirect wins anyway
  task automatic jump_to(input logic [23:0] a);
    @(negedge clk_sys_i);
    issue_ready_i = 1'b0;
    ce_i = 1'b1;
    jump_i = 1'b1;
    jump_addr_i = a;
    @(negedge clk_sys_i);
    jump_i = 1'b0;
    jump_addr_i = 24'($urandom);
    pa = a;
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rst_n_i, jump_i, issue_ready_i, slow, jump_addr_i} = '0;
    ce_i = 1'b1;
    void'($urandom(75137));
    for (i = 0; i < 256; i++) prog[i] = 16'($urandom);
    // Every format class up front, some constants crossing words
    pa = 0;
    for (i = 0; i < 24; i++) begin
      tpa[i] = pa;
      prog[pa][15:9] = (i < 16) ? 7'(i) : 7'(i + 32);
      pa = pa + 1 + clen(prog[pa][15:9]);
    end
    for (i = 0; i < 64; i++)
      u_ipd_mem_model.mem[i] = {prog[4*i], prog[4*i+1], prog[4*i+2], prog[4*i+3]};
    repeat (3) @(negedge clk_sys_i);
    chk(next_pa_o, 24'h0, "reset pa");
    rst_n_i = 1'b1;
    pa = 0;
    run(24);
    slow = 1'b1;
    run(40);
    for (k = 0; k < 24; k++) begin
      jump_to(tpa[23-k]);
      run(2);
    end
    // Reset in mid-run restarts from the reset address
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    pa = 0;
    run(10);
    report_and_stop();
  end
endmodule // test_instruction_parcel_decoder
`default_nettype wire
